/* logic/hbfp_pkg.sv */
// hbfp_pkg: constants, field layout and carrier types of the h-bridge supervisor
// assumes a 250 MHz core clock; all times are converted to cycles here
package hbfp_pkg;
   // clock rate
   localparam int CLK_MHZ        = 250;
   // digital dead time settings, ns and cycles (cycles = ns * MHz / 1000)
   localparam int DEAD_120_NS    = 120;
   localparam int DEAD_240_NS    = 240;
   localparam int DEAD_480_NS    = 480;
   localparam int DEAD_960_NS    = 960;
   localparam logic [7:0] DEAD_120_CYC = 8'(DEAD_120_NS * CLK_MHZ / 1000);
   localparam logic [7:0] DEAD_240_CYC = 8'(DEAD_240_NS * CLK_MHZ / 1000);
   localparam logic [7:0] DEAD_480_CYC = 8'(DEAD_480_NS * CLK_MHZ / 1000);
   localparam logic [7:0] DEAD_960_CYC = 8'(DEAD_960_NS * CLK_MHZ / 1000);
   // input deglitch, overcurrent deglitch and gate-drive interval (least times, round up)
   localparam int DEGLITCH_NS    = 200;
   localparam int OCP_DEG_NS     = 4000;
   localparam int DRIVE_NS       = 4000;
   localparam logic [5:0] DEGLITCH_CYC = 6'((DEGLITCH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] OCP_DEG_CYC  = 10'((OCP_DEG_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] DRIVE_CYC    = 10'((DRIVE_NS * CLK_MHZ + 999) / 1000);
   // retry interval; the cycle count is a top-level parameter
   localparam int RETRY_US       = 3000;
   localparam int RETRY_CYC_DEF  = RETRY_US * CLK_MHZ;
   // register offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   // control register fields
   localparam int CTRL_DEAD_POS  = 0;
   localparam int CTRL_CLR_POS   = 2;
   localparam int CTRL_VDS_POS   = 4;
   // status register fields
   localparam int STAT_FLAG_POS  = 0;
   localparam int STAT_PIN_POS   = 8;
   localparam int STAT_PROT_POS  = 9;
   localparam int STAT_VAR_POS   = 11;
   // reset values
   localparam logic [1:0] DEAD_SEL_RST = 2'h1;
   localparam logic [2:0] VDS_SEL_RST  = 3'h3;
   // threshold codes and trip levels in mV
   localparam logic [2:0] VDS_CODE_OFF = 3'h5;
   localparam logic [9:0] TRIP_060_MV  = 10'h03c;
   localparam logic [9:0] TRIP_120_MV  = 10'h078;
   localparam logic [9:0] TRIP_240_MV  = 10'h0f0;
   localparam logic [9:0] TRIP_480_MV  = 10'h1e0;
   localparam logic [9:0] TRIP_960_MV  = 10'h3c0;

   // protection states
   typedef enum logic [1:0] {PROT_RUN, PROT_HOLD, PROT_RETRY} hbfp_prot_e_t;

   // pin inputs from outside the clock domain
   typedef struct packed {
      logic [1:0] cmd_high;       // per half-bridge: 1 high fet, 0 low fet
      logic       drive_en;
      logic       supply_lockout;
      logic       pump_undervoltage;
      logic       thermal_shutdown;
      logic       sense_positive_over;
      logic [3:0] vds_over;       // {ls1,hs1,ls0,hs0}
      logic [3:0] gate_fb;        // gate above threshold, same order
      logic [2:0] drain_source_threshold_select;
      logic       pin_config;     // 1 = pin-configured variant
      logic       fault_pin;
   } hbfp_pins_t;

   // apb request and answer
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } hbfp_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } hbfp_apb_rsp_t;

   // gate and analog enables
   typedef struct packed {
      logic [1:0] high_gate;
      logic [1:0] low_gate;
      logic       pump_en;
      logic       regulator_en;
      logic       vds_mon_en;
      logic [9:0] trip_mv;
   } hbfp_drive_t;

   // whole state of the top module
   typedef struct packed {
      hbfp_pins_t      s1;
      hbfp_pins_t      s2;
      hbfp_pins_t      s3;
      hbfp_pins_t      stable;
      logic [1:0]      filt_cmd;
      logic [1:0][5:0] glitch_cnt;
      logic [1:0]      side;
      logic [1:0][7:0] dead_cnt;
      hbfp_drive_t     drv;
      hbfp_prot_e_t    prot;
      logic [19:0]     retry_cnt;
      logic [9:0]      ocp_cnt;
      logic [9:0]      drv_cnt;
      logic [4:0]      flags;     // {overtemp,gate,overcurrent,pump,supply}
      logic [1:0]      dead_sel;
      logic [2:0]      vds_sel;
      hbfp_apb_rsp_t   rsp;
      logic            fault_oe_n;
   } hbfp_state_t;
endpackage : hbfp_pkg

/* logic/hbfp_top.sv */
// hbfp_top: dead time, input deglitch and fault supervision for one h-bridge
// assumes an apb master on clk_in; analog comparators arrive as async pins
`timescale 1ns/1ps
module hbfp_top
   import hbfp_pkg::*;
#(
   parameter logic [19:0] RETRY_CYC = 20'(RETRY_CYC_DEF)
) (
   // clock, enable, reset (logic undervoltage)
   input  wire logic          clk_in,
   input  wire logic          clk_en_in,
   input  wire logic          nrst_in,
   // register bus
   input  wire hbfp_apb_req_t apb_in,
   output hbfp_apb_rsp_t      apb_out,
   // pins and comparators
   input  wire hbfp_pins_t    pins_in,
   // gate drive and analog enables
   output hbfp_drive_t        drive_out,
   // open-drain fault pin
   output logic               fault_out_n_o_out,
   output logic               fault_out_n_oe_n_out
);

   hbfp_state_t st_reg;
   hbfp_state_t st_next;

   localparam hbfp_state_t ST_RST = '{
      drv:       '0,
      prot:      PROT_HOLD,
      dead_sel:  DEAD_SEL_RST,
      vds_sel:   VDS_SEL_RST,
      fault_oe_n: 1'b0,
      default:   '0
   };

   // combinational helpers
   logic       hold_cond;
   logic       ocp_evt;
   logic       gdf_evt;
   logic       drive_off;
   logic       wr_ctrl;
   logic       clr_pulse;
   logic [3:0] gates_on;
   logic [4:0] flag_set;
   logic [7:0] dead_len;
   logic [2:0] vds_code;
   logic [31:0] rd_data;

   // next-state logic
   always_comb begin
      st_next = st_reg;
      // three-stage synchroniser; a bit counts once stages two and three agree
      st_next.s1 = pins_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.stable = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3)
                     | ((st_reg.s2 ^ st_reg.s3) & st_reg.stable);

      // input deglitch per half-bridge command
      for (int i = 0; i < 2; i++) begin
         if (st_reg.stable.cmd_high[i] != st_reg.filt_cmd[i]) begin
            if (st_reg.glitch_cnt[i] == DEGLITCH_CYC - 6'h01) begin
               st_next.filt_cmd[i]   = st_reg.stable.cmd_high[i];
               st_next.glitch_cnt[i] = 6'h00;
            end else begin
               st_next.glitch_cnt[i] = st_reg.glitch_cnt[i] + 6'h01;
            end
         end else begin
            st_next.glitch_cnt[i] = 6'h00;
         end
      end

      // dead time selection
      if (st_reg.stable.pin_config) begin
         dead_len = DEAD_240_CYC;
      end else begin
         unique case (st_reg.dead_sel)
            2'h0: dead_len = DEAD_120_CYC;
            2'h1: dead_len = DEAD_240_CYC;
            2'h2: dead_len = DEAD_480_CYC;
            2'h3: dead_len = DEAD_960_CYC;
         endcase
      end

      // threshold decode; code five and above disables monitoring
      vds_code = st_reg.stable.pin_config ? st_reg.stable.drain_source_threshold_select
                                          : st_reg.vds_sel;
      st_next.drv.vds_mon_en = 1'b1;
      unique case (vds_code)
         3'h0:    st_next.drv.trip_mv = TRIP_060_MV;
         3'h1:    st_next.drv.trip_mv = TRIP_120_MV;
         3'h2:    st_next.drv.trip_mv = TRIP_240_MV;
         3'h3:    st_next.drv.trip_mv = TRIP_480_MV;
         3'h4:    st_next.drv.trip_mv = TRIP_960_MV;
         default: begin
            st_next.drv.trip_mv    = 10'h000;
            st_next.drv.vds_mon_en = 1'b0;
         end
      endcase

      // conditions that hold the bridge off while present
      hold_cond = st_reg.stable.supply_lockout | st_reg.stable.pump_undervoltage
                | st_reg.stable.thermal_shutdown;
      gates_on  = {st_reg.drv.low_gate[1], st_reg.drv.high_gate[1],
                   st_reg.drv.low_gate[0], st_reg.drv.high_gate[0]};

      // overcurrent deglitch on fets that are driven
      ocp_evt = 1'b0;
      if (st_reg.prot == PROT_RUN && st_reg.drv.vds_mon_en
          && |(st_reg.stable.vds_over & gates_on)) begin
         if (st_reg.ocp_cnt == OCP_DEG_CYC) begin
            ocp_evt = 1'b1;
         end else begin
            st_next.ocp_cnt = st_reg.ocp_cnt + 10'h001;
         end
      end else begin
         st_next.ocp_cnt = 10'h000;
      end

      // gate-drive interval: timer restarts on each gate change
      gdf_evt = 1'b0;
      if (st_reg.drv_cnt == DRIVE_CYC) begin
         gdf_evt = (st_reg.prot == PROT_RUN) && (st_reg.stable.gate_fb != gates_on);
      end else begin
         st_next.drv_cnt = st_reg.drv_cnt + 10'h001;
      end

      // protection state machine
      unique case (st_reg.prot)
         PROT_RUN: begin
            if (hold_cond) begin
               st_next.prot = PROT_HOLD;
            end else if (ocp_evt || gdf_evt || st_reg.stable.sense_positive_over) begin
               st_next.prot      = PROT_RETRY;
               st_next.retry_cnt = RETRY_CYC;
            end
         end
         PROT_HOLD: begin
            if (!hold_cond) begin
               st_next.prot = PROT_RUN;
            end
         end
         PROT_RETRY: begin
            if (hold_cond) begin
               st_next.prot = PROT_HOLD;
            end else if (st_reg.retry_cnt <= 20'h0_0001) begin
               st_next.prot      = PROT_RUN;
               st_next.retry_cnt = 20'h0_0000;
            end else begin
               st_next.retry_cnt = st_reg.retry_cnt - 20'h0_0001;
            end
         end
      endcase
      // gate timer restarts whenever the protection state changes
      if (st_next.prot != st_reg.prot) begin
         st_next.drv_cnt = 10'h000;
      end

      // half-bridge commutation with dead time
      drive_off = (st_reg.prot != PROT_RUN) || !st_reg.stable.drive_en;
      for (int i = 0; i < 2; i++) begin
         if (drive_off) begin
            st_next.drv.high_gate[i] = 1'b0;
            st_next.drv.low_gate[i]  = 1'b0;
            st_next.dead_cnt[i]      = dead_len;
         end else if (st_reg.filt_cmd[i] != st_reg.side[i]) begin
            st_next.drv.high_gate[i] = 1'b0;
            st_next.drv.low_gate[i]  = 1'b0;
            st_next.side[i]          = st_reg.filt_cmd[i];
            st_next.dead_cnt[i]      = dead_len;
         end else if (st_reg.dead_cnt[i] != 8'h00) begin
            st_next.dead_cnt[i] = st_reg.dead_cnt[i] - 8'h01;
         end else begin
            st_next.drv.high_gate[i] = st_reg.side[i];
            st_next.drv.low_gate[i]  = !st_reg.side[i];
         end
      end

      // gate timer restarts on each gate change, so lagging feedback never trips it
      if (gates_on != {st_next.drv.low_gate[1], st_next.drv.high_gate[1],
                       st_next.drv.low_gate[0], st_next.drv.high_gate[0]}) begin
         st_next.drv_cnt = 10'h000;
      end

      // charge pump and regulator enables
      st_next.drv.pump_en      = !(st_reg.stable.supply_lockout
                                   | st_reg.stable.thermal_shutdown);
      st_next.drv.regulator_en = !st_reg.stable.thermal_shutdown;

      // fault pin pulled low whenever not running
      st_next.fault_oe_n = (st_next.prot == PROT_RUN);

      // register writes take effect at the completing access edge
      wr_ctrl   = apb_in.psel && apb_in.penable && st_reg.rsp.pready
                  && apb_in.pwrite && apb_in.paddr == CTRL_OFS;
      clr_pulse = wr_ctrl && apb_in.pwdata[CTRL_CLR_POS];
      if (wr_ctrl) begin
         st_next.dead_sel = apb_in.pwdata[CTRL_DEAD_POS +: 2];
         st_next.vds_sel  = apb_in.pwdata[CTRL_VDS_POS +: 3];
      end

      // sticky flags, a new event wins over a clear
      flag_set = {st_reg.stable.thermal_shutdown, gdf_evt,
                  ocp_evt | st_reg.stable.sense_positive_over,
                  st_reg.stable.pump_undervoltage, st_reg.stable.supply_lockout};
      st_next.flags = ((clr_pulse ? 5'h00 : st_reg.flags) | flag_set);

      // read data mux
      rd_data = 32'h0000_0000;
      if (apb_in.paddr == CTRL_OFS) begin
         rd_data[CTRL_DEAD_POS +: 2] = st_reg.dead_sel;
         rd_data[CTRL_VDS_POS +: 3]  = st_reg.vds_sel;
      end else if (apb_in.paddr == STATUS_OFS) begin
         rd_data[STAT_FLAG_POS +: 5] = st_reg.flags;
         rd_data[STAT_PIN_POS]       = st_reg.stable.fault_pin;
         rd_data[STAT_PROT_POS +: 2] = st_reg.prot;
         rd_data[STAT_VAR_POS]       = st_reg.stable.pin_config;
      end

      // apb answer: ready in the first access cycle
      if (apb_in.psel && !apb_in.penable) begin
         st_next.rsp.pready  = 1'b1;
         st_next.rsp.pslverr = (apb_in.paddr != CTRL_OFS) && (apb_in.paddr != STATUS_OFS);
         st_next.rsp.prdata  = apb_in.pwrite ? 32'h0000_0000 : rd_data;
      end else begin
         st_next.rsp = '0;
      end
   end

   // state register; reset is the logic undervoltage event
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         st_reg <= ST_RST;
      end else if (clk_en_in) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register; the fault pin level is tied low
   assign apb_out              = st_reg.rsp;
   assign drive_out            = st_reg.drv;
   assign fault_out_n_o_out    = 1'b0;
   assign fault_out_n_oe_n_out = st_reg.fault_oe_n;

   // checks
   a_no_shoot_thru: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !(st_reg.drv.high_gate[0] && st_reg.drv.low_gate[0])
      && !(st_reg.drv.high_gate[1] && st_reg.drv.low_gate[1]))
      else $error("both fets of a half-bridge on");
   a_dead_gap_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $rose(st_reg.drv.low_gate[0]) |-> $past(!st_reg.drv.high_gate[0]
                                              && st_reg.dead_cnt[0] == 8'h00))
      else $error("low fet on without dead time");
   a_fault_pin_run: assert property (@(posedge clk_in) disable iff (!nrst_in)
      st_reg.fault_oe_n == (st_reg.prot == PROT_RUN))
      else $error("fault pin disagrees with protection state");
   a_gates_off_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st_reg.prot != PROT_RUN && clk_en_in) |=> (st_reg.drv.high_gate == 2'b00
                                                  && st_reg.drv.low_gate == 2'b00))
      else $error("gates on during fault");
   a_retry_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st_reg.prot == PROT_RETRY && $past(st_reg.prot) == PROT_RUN)
      |-> st_reg.retry_cnt == RETRY_CYC)
      else $error("retry timer not restarted");
   a_flag_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st_reg.flags[2] && clk_en_in && !clr_pulse) |=> st_reg.flags[2])
      else $error("overcurrent flag dropped without clear");
   a_uv_pump_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st_reg.stable.supply_lockout && clk_en_in) |=> (!st_reg.drv.pump_en
                                                      && st_reg.flags[0]))
      else $error("pump on or flag clear during supply lockout");
   a_thermal_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st_reg.stable.thermal_shutdown && clk_en_in) |=> (!st_reg.drv.regulator_en
                                                        && st_reg.prot != PROT_RUN))
      else $error("regulator on during thermal shutdown");
   a_vds_disabled: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!st_reg.drv.vds_mon_en && clk_en_in) |=> st_reg.ocp_cnt == 10'h000)
      else $error("overcurrent timer runs with monitor disabled");
   a_logic_reset: assert property (@(posedge clk_in)
      !nrst_in |=> (!st_reg.fault_oe_n && st_reg.flags == 5'h00))
      else $error("fault pin released in logic undervoltage");

endmodule : hbfp_top

/* tb/hbfp_bridge_model.sv */
// hbfp_bridge_model: external fets seen by the supervisor
// assumes gate outputs of hbfp_top; feedback trails the gates one cycle
`timescale 1ns/1ps
module hbfp_bridge_model
   import hbfp_pkg::*;
(
   // clock and gate drive from the device
   input  wire logic        clk_in,
   input  wire hbfp_drive_t drive_in,
   // fault injection from the bench
   input  wire logic        stuck_in,
   input  wire logic        over_in,
   // gate feedback and drain-source comparators
   output logic [3:0]       gate_fb_out,
   output logic [3:0]       vds_over_out
);
   logic [3:0] gates;
   // order {ls1,hs1,ls0,hs0}
   assign gates = {drive_in.low_gate[1], drive_in.high_gate[1],
                   drive_in.low_gate[0], drive_in.high_gate[0]};
   // gate voltage follows unless a short holds it
   always_ff @(posedge clk_in) begin
      if (!stuck_in) begin
         gate_fb_out <= gates;
      end
   end
   // only a driven fet shows a drain-source drop
   assign vds_over_out = over_in ? gates : 4'h0;
endmodule : hbfp_bridge_model

/* tb/hbfp_tb_top.sv */
// hbfp_tb_top: self-checking bench of the h-bridge supervisor
// assumes hbfp_top with retry shortened to 200 cycles and the bridge model
`timescale 1ns/1ps
module hbfp_tb_top;
   import hbfp_pkg::*;
   localparam logic [19:0] RETRY = 20'h0_00c8;
   logic          clk_in = 1'b0;
   logic          nrst_in = 1'b0;
   logic          oe_n, o_n, err;
   logic          stuck = 1'b0;
   logic          over = 1'b0;
   logic [3:0]    fb, vo;
   logic [31:0]   rd;
   logic [31:0]   ctrl;
   hbfp_apb_req_t apb_in = '0;
   hbfp_apb_rsp_t apb_out;
   hbfp_pins_t    pins = '0;
   hbfp_pins_t    pins_in;
   hbfp_drive_t   drive_out;
   int            error_cnt = 0;
   int            n_tests = 0;
   int            i, n, sel;
   // clock
   always #2 clk_in = ~clk_in;
   // fault wire with pull-up, read back on its pin
   always_comb begin
      pins_in = pins;
      pins_in.gate_fb = fb;
      pins_in.vds_over = vo;
      pins_in.fault_pin = oe_n ? 1'b1 : o_n;
   end
   hbfp_top #(.RETRY_CYC(RETRY)) dut (.clk_in(clk_in), .clk_en_in(1'b1), .nrst_in(nrst_in),
      .apb_in(apb_in), .apb_out(apb_out), .pins_in(pins_in), .drive_out(drive_out),
      .fault_out_n_o_out(o_n), .fault_out_n_oe_n_out(oe_n));
   hbfp_bridge_model fets (.clk_in(clk_in), .drive_in(drive_out), .stuck_in(stuck),
      .over_in(over), .gate_fb_out(fb), .vds_over_out(vo));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   task automatic hang();
      error_cnt++;
      finish_test();
   endtask : hang
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_in);
      apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_in);
      apb_in.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (apb_out.pready !== 1'b1 && k < 20);
      if (apb_out.pready !== 1'b1) hang();
      rd = apb_out.prdata;
      err = apb_out.pslverr;
      apb_in <= '0;
   endtask : apb
   task automatic wait_oe(input logic v, input int lim);
      int k;
      k = 0;
      do begin
         @(negedge clk_in);
         k++;
      end while (oe_n !== v && k < lim);
      if (oe_n !== v) hang();
   endtask : wait_oe
   // negedges until half h becomes idle (both gates off) or not
   task automatic gate_wait(input int h, input logic idle, input int lim, output int m);
      m = 0;
      do begin
         @(negedge clk_in);
         m++;
      end while (((drive_out.high_gate[h] | drive_out.low_gate[h]) === 1'b0) !== idle
                 && m < lim);
      if (m >= lim) hang();
   endtask : gate_wait
   // toggle a half and count idle cycles before the opposite gate
   task automatic dead(input int h, input int exp);
      @(posedge clk_in);
      pins.cmd_high[h] <= ~pins.cmd_high[h];
      gate_wait(h, 1'b1, 200, n);
      gate_wait(h, 1'b0, 400, n);
      chk(n, exp);
      chk(drive_out.high_gate[h], pins.cmd_high[h]);
   endtask : dead
   function automatic int dead_exp(input int s);
      case (s)
         0: return DEAD_120_CYC + 1;
         1: return DEAD_240_CYC + 1;
         2: return DEAD_480_CYC + 1;
         default: return DEAD_960_CYC + 1;
      endcase
   endfunction : dead_exp
   function automatic logic [9:0] trip_exp(input int c);
      case (c)
         0: return TRIP_060_MV;
         1: return TRIP_120_MV;
         2: return TRIP_240_MV;
         3: return TRIP_480_MV;
         4: return TRIP_960_MV;
         default: return 10'h000;
      endcase
   endfunction : trip_exp
   // main sequence
   initial begin
      void'($urandom(72003));
      pins.drive_en = 1'b1;
      repeat (6) @(posedge clk_in);
      chk(oe_n, 1'b0);
      nrst_in <= 1'b1;
      wait_oe(1'b1, 30);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h0000_0031);
      apb(1'b0, 8'h08, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0000_0000);
      // let the initial dead time after release run out first
      repeat (100) @(posedge clk_in);
      // dead time for four randomly drawn settings
      for (i = 0; i < 4; i++) begin
         sel = $urandom % 4;
         ctrl = 32'h0000_0030 | sel;
         apb(1'b1, CTRL_OFS, ctrl);
         dead(i % 2, dead_exp(sel));
      end
      // short random pulses never reach the gates
      for (i = 0; i < 3; i++) begin
         @(posedge clk_in);
         pins.cmd_high[0] <= ~pins.cmd_high[0];
         repeat (5 + $urandom % 40) @(posedge clk_in);
         pins.cmd_high[0] <= ~pins.cmd_high[0];
         n = 0;
         repeat (90) begin
            @(negedge clk_in);
            n += int'(drive_out.high_gate[0] | drive_out.low_gate[0]);
         end
         chk(n, 90);
      end
      // pin variant: threshold decode and fixed dead time
      pins.pin_config <= 1'b1;
      for (i = 0; i < 6; i++) begin
         pins.drain_source_threshold_select <= 3'(i);
         repeat (12) @(posedge clk_in);
         chk(drive_out.trip_mv, trip_exp(i));
         chk(drive_out.vds_mon_en, i != 5);
      end
      pins.drain_source_threshold_select <= 3'h3;
      dead(1, DEAD_240_CYC + 1);
      pins.pin_config <= 1'b0;
      // comparator held on: no trip for 700 cycles inside the deglitch, then trips
      over <= 1'b1;
      n = 0;
      repeat (700) begin
         @(negedge clk_in);
         n += int'(oe_n);
      end
      chk(n, 700);
      wait_oe(1'b0, 500);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[2], 1'b1);
      wait_oe(1'b1, RETRY + 20);
      wait_oe(1'b0, 1400);
      over <= 1'b0;
      wait_oe(1'b1, RETRY + 20);
      apb(1'b1, CTRL_OFS, ctrl | 32'h4);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[4:0], 5'h00);
      pins.sense_positive_over <= 1'b1;
      wait_oe(1'b0, 20);
      pins.sense_positive_over <= 1'b0;
      wait_oe(1'b1, RETRY + 20);
      // gate held by a short
      stuck <= 1'b1;
      pins.cmd_high[1] <= ~pins.cmd_high[1];
      wait_oe(1'b0, 1400);
      stuck <= 1'b0;
      wait_oe(1'b1, RETRY + 20);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[3:2], 2'h3);
      apb(1'b1, CTRL_OFS, ctrl | 32'h4);
      // lockout, pump and thermal holds
      for (i = 0; i < 3; i++) begin
         pins.supply_lockout <= (i == 0);
         pins.pump_undervoltage <= (i == 1);
         pins.thermal_shutdown <= (i == 2);
         wait_oe(1'b0, 20);
         repeat (3) @(negedge clk_in);
         chk({drive_out.high_gate, drive_out.low_gate}, 4'h0);
         chk({drive_out.pump_en, drive_out.regulator_en}, {i == 1, i != 2});
         pins <= '{drive_en: 1'b1, cmd_high: pins.cmd_high, drain_source_threshold_select: 3'h3,
                   default: 1'b0};
         wait_oe(1'b1, 40);
         apb(1'b0, STATUS_OFS, 32'h0);
         chk(rd[4:0], (i == 2) ? 5'h10 : 5'(1 << i));
         apb(1'b0, CTRL_OFS, 32'h0);
         chk(rd, ctrl);
         apb(1'b1, CTRL_OFS, ctrl | 32'h4);
      end
      finish_test();
   end
endmodule : hbfp_tb_top
